// ### rtl/pcf_top.sv
// control frame configuration block with register slave and delay line
// Notes on behaviour
// - error in a control frame sets a sticky flag, cleared by reading config
// - frame completed cleanly sets a sticky ok flag, cleared by reading config
// - five reserved config bits ignore writes and read as zero
// - address select bit picks the first or second fixed destination address
// - selected address with first octet multicast bit set also matches
// - nonzero irq control routes frame events into status, replacing half-full
// - irq control 00 off, low bit on success, high bit on error
// - broadcast disable clear accepts broadcast phy address and own address
// - broadcast disable set accepts only the exact own phy address
// - four-bit buffer size sets transmit delay depth for all packets
// - buffer size zero passes with one clock of delay, truncating control frames after address
// - frame write enable gates frame writes, reset value from a strap
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/10ps
module pcf_top
    import pcf_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic [4:0]        phy_addr,
    input  wire logic              strap_write_enable,
    input  wire logic              rx_half_full_event,
    input  wire logic              tx_valid,
    input  wire logic [7:0]        tx_data,
    output logic                   tx_out_valid,
    output logic [7:0]             tx_out_data,
    output logic                   frame_wr_pulse,
    output logic [4:0]             frame_wr_reg,
    output logic [15:0]            frame_wr_data,
    output logic                   irq
);
    initial begin
        if (ADDR_W < 8) $error("pcf_top: ADDR_W below 8");
    end

    pcf_evt_if ev ();

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic [2:0]        sync_ff,  nxt_sync;
    logic              spend_ff, nxt_spend;
    logic [8:0]        cfg_ff,   nxt_cfg;
    logic              ferr_ff,  nxt_ferr;
    logic              fok_ff,   nxt_fok;
    logic [2:0]        sts_ff,   nxt_sts;
    logic [2:0]        msk_ff,   nxt_msk;
    logic              irq_ff,   nxt_irq;
    logic              fwp_ff,   nxt_fwp;
    logic [4:0]        fwr_ff,   nxt_fwr;
    logic [15:0]       fwd_ff,   nxt_fwd;
    logic              awg_ff,   nxt_awg;
    logic [ADDR_W-1:0] awa_ff,   nxt_awa;
    logic              wg_ff,    nxt_wg;
    logic [31:0]       wd_ff,    nxt_wd;
    logic [3:0]        ws_ff,    nxt_ws;
    logic              bv_ff,    nxt_bv;
    logic [1:0]        br_ff,    nxt_br;
    logic              rv_ff,    nxt_rv;
    logic [31:0]       rd_ff,    nxt_rd;
    logic [1:0]        rr_ff,    nxt_rr;

    logic              wr_go;
    logic              rd_go;
    logic [1:0]        wsel;
    logic [1:0]        rsel;
    logic              cfg_rd;
    logic [1:0]        irq_ctl;
    logic              frame_cfg_wr;
    logic [15:0]       cfg_view;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] a);
        if (a[1:0] != 2'h0 || (ADDR_W > 8 && (a >> 8) != '0)) return SEL_NONE;
        unique case (a[7:2])
            CFG_IDX: return SEL_CFG;
            STS_IDX: return SEL_STS;
            MSK_IDX: return SEL_MSK;
            default: return SEL_NONE;
        endcase
    endfunction : reg_sel

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                          input logic [1:0] strb, input logic [15:0] rw);
        logic [15:0] m;
        m = rw & {{8{strb[1]}}, {8{strb[0]}}};
        return (old & ~m) | (wd & m);
    endfunction : merge

    // ---------------------------------------------------------------
    // submodules
    // ---------------------------------------------------------------
    pcf_parse u_parse (
        .clk                (clk),
        .reset              (reset),
        .tx_valid           (tx_valid),
        .tx_data            (tx_data),
        .dest_addr_select   (cfg_ff[CFG_DA_BIT]),
        .broadcast_disable  (cfg_ff[CFG_BC_BIT]),
        .buf_zero           (cfg_ff[CFG_BUF_LO +: 4] == 4'h0),
        .frame_write_enable (cfg_ff[CFG_EN_BIT]),
        .own_phy            (phy_addr),
        .ev                 (ev.src)
    );

    pcf_dly #(
        .STAGES (MAX_DELAY)
    ) u_dly (
        .clk          (clk),
        .reset        (reset),
        .in_valid     (tx_valid && !ev.squash),
        .in_data      (tx_data),
        .depth        (cfg_ff[CFG_BUF_LO +: 4]),
        .out_valid_ff (tx_out_valid),
        .out_data_ff  (tx_out_data)
    );

    // ---------------------------------------------------------------
    // bus handshake
    // ---------------------------------------------------------------
    always_comb begin
        wr_go    = awg_ff && wg_ff && !bv_ff;
        rd_go    = s_axi_arvalid && !rv_ff;
        wsel     = reg_sel(awa_ff);
        rsel     = reg_sel(s_axi_araddr);
        cfg_rd   = rd_go && rsel == SEL_CFG;
        irq_ctl  = cfg_ff[CFG_INT_LO +: 2];
        cfg_view = {ferr_ff, fok_ff, 5'h00, cfg_ff};
        nxt_awg  = awg_ff;
        nxt_awa  = awa_ff;
        nxt_wg   = wg_ff;
        nxt_wd   = wd_ff;
        nxt_ws   = ws_ff;
        nxt_bv   = bv_ff;
        nxt_br   = br_ff;
        nxt_rv   = rv_ff;
        nxt_rd   = rd_ff;
        nxt_rr   = rr_ff;
        if (s_axi_awvalid && !awg_ff) begin
            nxt_awg = 1'b1;
            nxt_awa = s_axi_awaddr;
        end
        if (s_axi_wvalid && !wg_ff) begin
            nxt_wg = 1'b1;
            nxt_wd = s_axi_wdata;
            nxt_ws = s_axi_wstrb;
        end
        if (wr_go) begin
            nxt_awg = 1'b0;
            nxt_wg  = 1'b0;
            nxt_bv  = 1'b1;
            nxt_br  = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (bv_ff && s_axi_bready) begin
            nxt_bv = 1'b0;
        end
        if (rd_go) begin
            nxt_rv = 1'b1;
            nxt_rr = RESP_OKAY;
            unique case (rsel)
                SEL_CFG: nxt_rd = {16'h0000, cfg_view};
                SEL_STS: nxt_rd = {29'h00000000, sts_ff};
                SEL_MSK: nxt_rd = {29'h00000000, msk_ff};
                SEL_NONE: begin
                    nxt_rd = 32'h00000000;
                    nxt_rr = RESP_SLVERR;
                end
            endcase
        end else if (rv_ff && s_axi_rready) begin
            nxt_rv = 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // configuration, flags and interrupt
    // ---------------------------------------------------------------
    always_comb begin
        nxt_sync  = {sync_ff[1:0], strap_write_enable};
        nxt_spend = spend_ff;
        nxt_cfg   = cfg_ff;
        frame_cfg_wr = ev.wr && ev.wr_reg == CFG_IDX[4:0];
        if (spend_ff && sync_ff[1] == sync_ff[2]) begin
            nxt_cfg[CFG_EN_BIT] = sync_ff[2];
            nxt_spend = 1'b0;
        end
        if (wr_go && wsel == SEL_CFG) begin
            nxt_cfg = 9'(merge(cfg_view, wd_ff[15:0], ws_ff[1:0], CFG_RW_MASK));
        end else if (frame_cfg_wr) begin
            nxt_cfg = ev.wr_data[8:0];
        end
        // set wins over clear on read
        nxt_ferr = ev.err || (ferr_ff && !cfg_rd);
        nxt_fok  = ev.ok || (fok_ff && !cfg_rd);
        nxt_sts  = sts_ff;
        if (wr_go && wsel == SEL_STS && ws_ff[0]) begin
            nxt_sts = sts_ff & ~wd_ff[2:0];
        end
        if (cfg_rd) begin
            nxt_sts[STS_ERR_BIT:STS_OK_BIT] = 2'h0;
        end
        if (ev.ok && irq_ctl[0]) nxt_sts[STS_OK_BIT] = 1'b1;
        if (ev.err && irq_ctl[1]) nxt_sts[STS_ERR_BIT] = 1'b1;
        if (rx_half_full_event && irq_ctl == 2'h0) nxt_sts[STS_RHF_BIT] = 1'b1;
        nxt_msk = msk_ff;
        if (wr_go && wsel == SEL_MSK && ws_ff[0]) begin
            nxt_msk = wd_ff[2:0];
        end
        nxt_irq = |(nxt_sts & nxt_msk);
        nxt_fwp = ev.wr;
        nxt_fwr = ev.wr ? ev.wr_reg : fwr_ff;
        nxt_fwd = ev.wr ? ev.wr_data : fwd_ff;
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        sync_ff <= nxt_sync;
        if (reset) begin
            spend_ff <= 1'b1;
            cfg_ff   <= CFG_RESET;
            ferr_ff  <= 1'b0;
            fok_ff   <= 1'b0;
            sts_ff   <= STS_RESET;
            msk_ff   <= STS_RESET;
            irq_ff   <= 1'b0;
            fwp_ff   <= 1'b0;
            fwr_ff   <= 5'h00;
            fwd_ff   <= 16'h0000;
            awg_ff   <= 1'b0;
            awa_ff   <= '0;
            wg_ff    <= 1'b0;
            wd_ff    <= 32'h00000000;
            ws_ff    <= 4'h0;
            bv_ff    <= 1'b0;
            br_ff    <= RESP_OKAY;
            rv_ff    <= 1'b0;
            rd_ff    <= 32'h00000000;
            rr_ff    <= RESP_OKAY;
        end else begin
            spend_ff <= nxt_spend;
            cfg_ff   <= nxt_cfg;
            ferr_ff  <= nxt_ferr;
            fok_ff   <= nxt_fok;
            sts_ff   <= nxt_sts;
            msk_ff   <= nxt_msk;
            irq_ff   <= nxt_irq;
            fwp_ff   <= nxt_fwp;
            fwr_ff   <= nxt_fwr;
            fwd_ff   <= nxt_fwd;
            awg_ff   <= nxt_awg;
            awa_ff   <= nxt_awa;
            wg_ff    <= nxt_wg;
            wd_ff    <= nxt_wd;
            ws_ff    <= nxt_ws;
            bv_ff    <= nxt_bv;
            br_ff    <= nxt_br;
            rv_ff    <= nxt_rv;
            rd_ff    <= nxt_rd;
            rr_ff    <= nxt_rr;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign s_axi_awready  = !awg_ff;
    assign s_axi_wready   = !wg_ff;
    assign s_axi_bvalid   = bv_ff;
    assign s_axi_bresp    = br_ff;
    assign s_axi_arready  = !rv_ff;
    assign s_axi_rvalid   = rv_ff;
    assign s_axi_rdata    = rd_ff;
    assign s_axi_rresp    = rr_ff;
    assign irq            = irq_ff;
    assign frame_wr_pulse = fwp_ff;
    assign frame_wr_reg   = fwr_ff;
    assign frame_wr_data  = fwd_ff;
endmodule : pcf_top

// ### rtl/pcf_pkg.sv
// constants for the control frame configuration block
package pcf_pkg;
    // ---------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ---------------------------------------------------------------
    localparam logic [5:0]  CFG_IDX      = 6'h1F;
    localparam logic [5:0]  STS_IDX      = 6'h20;
    localparam logic [5:0]  MSK_IDX      = 6'h21;
    localparam logic [1:0]  SEL_NONE     = 2'h0;
    localparam logic [1:0]  SEL_CFG      = 2'h1;
    localparam logic [1:0]  SEL_STS      = 2'h2;
    localparam logic [1:0]  SEL_MSK      = 2'h3;
    // ---------------------------------------------------------------
    // configuration fields
    // ---------------------------------------------------------------
    localparam int          CFG_ERR_BIT  = 15;
    localparam int          CFG_OK_BIT   = 14;
    localparam int          CFG_DA_BIT   = 8;
    localparam int          CFG_INT_LO   = 6;
    localparam int          CFG_BC_BIT   = 5;
    localparam int          CFG_BUF_LO   = 1;
    localparam int          CFG_EN_BIT   = 0;
    localparam logic [15:0] CFG_RW_MASK  = 16'h01FF;
    localparam logic [8:0]  CFG_RESET    = 9'h000;
    // ---------------------------------------------------------------
    // interrupt status and mask fields
    // ---------------------------------------------------------------
    localparam int          STS_OK_BIT   = 0;
    localparam int          STS_ERR_BIT  = 1;
    localparam int          STS_RHF_BIT  = 2;
    localparam logic [2:0]  STS_RESET    = 3'h0;
    // ---------------------------------------------------------------
    // frame layout and addresses (address values arbitrary)
    // ---------------------------------------------------------------
    localparam logic [47:0] DEST_ADDR_A  = 48'h02_11_22_33_44_55;
    localparam logic [47:0] DEST_ADDR_B  = 48'h02_11_22_00_00_00;
    localparam logic [7:0]  MCAST_BIT    = 8'h01;
    localparam logic [4:0]  BCAST_PHY    = 5'h1F;
    localparam logic [3:0]  IDX_DA_LAST  = 4'h5;
    localparam logic [3:0]  IDX_PHY      = 4'h6;
    localparam logic [3:0]  IDX_REG      = 4'h7;
    localparam logic [3:0]  IDX_DHI      = 4'h8;
    localparam logic [3:0]  IDX_DLO      = 4'h9;
    localparam int          MAX_DELAY    = 15;
    // ---------------------------------------------------------------
    // bus answers
    // ---------------------------------------------------------------
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DA   = 2'b01,
        ST_HDR  = 2'b10,
        ST_SKIP = 2'b11
    } pcf_state_t;
endpackage : pcf_pkg

// ### rtl/pcf_evt_if.sv
// events from the frame parser to the register logic
`timescale 1ns/10ps
interface pcf_evt_if;
    logic        ok;
    logic        err;
    logic        wr;
    logic [4:0]  wr_reg;
    logic [15:0] wr_data;
    logic        squash;
    modport src (output ok, output err, output wr, output wr_reg, output wr_data, output squash);
    modport snk (input ok, input err, input wr, input wr_reg, input wr_data, input squash);
endinterface : pcf_evt_if

// ### rtl/pcf_dly.sv
// transmit delay buffer of selectable depth
`timescale 1ns/10ps
module pcf_dly
    import pcf_pkg::*;
#(
    parameter int STAGES = 15
) (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       in_valid,
    input  wire logic [7:0] in_data,
    input  wire logic [3:0] depth,
    output logic            out_valid_ff,
    output logic [7:0]      out_data_ff
);
    initial begin
        if (STAGES < MAX_DELAY) $error("pcf_dly: STAGES too small");
    end

    logic [8:0] sr_ff  [STAGES];
    logic [8:0] nxt_sr [STAGES];
    logic [8:0] tap;

    // ---------------------------------------------------------------
    // shift line, every byte passes it
    // ---------------------------------------------------------------
    always_comb begin
        nxt_sr[0] = {in_valid, in_data};
        for (int i = 1; i < STAGES; i++) begin
            nxt_sr[i] = sr_ff[i-1];
        end
        if (depth == 4'h0) begin
            tap = {in_valid, in_data};
        end else begin
            tap = sr_ff[4'(depth - 4'h1)];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            sr_ff        <= '{default: 9'h000};
            out_valid_ff <= 1'b0;
            out_data_ff  <= 8'h00;
        end else begin
            sr_ff        <= nxt_sr;
            out_valid_ff <= tap[8];
            out_data_ff  <= tap[7:0];
        end
    end
endmodule : pcf_dly

// ### rtl/pcf_parse.sv
// control frame recogniser on the transmit byte stream
`timescale 1ns/10ps
module pcf_parse
    import pcf_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    input  wire logic       dest_addr_select,
    input  wire logic       broadcast_disable,
    input  wire logic       buf_zero,
    input  wire logic       frame_write_enable,
    input  wire logic [4:0] own_phy,
    pcf_evt_if.src          ev
);
    pcf_state_t  st_ff,  nxt_st;
    logic [3:0]  idx_ff, nxt_idx;
    logic        hit_ff, nxt_hit;
    logic [4:0]  phy_ff, nxt_phy;
    logic [4:0]  reg_ff, nxt_reg;
    logic [7:0]  dhi_ff, nxt_dhi;
    logic        sq_ff,  nxt_sq;
    logic        ok_ff,  nxt_ok;
    logic        err_ff, nxt_err;
    logic        wr_ff,  nxt_wr;
    logic        phy_ok;
    logic [7:0]  dlo_ff;

    // destination byte match, multicast variant accepted on first octet
    function automatic logic da_byte_ok(input logic [3:0] i, input logic [7:0] d,
                                        input logic sel);
        logic [47:0] da;
        logic [7:0]  e;
        da = sel ? DEST_ADDR_B : DEST_ADDR_A;
        e  = da[8'(47 - 8*i) -: 8];
        return (d == e) || (i == 4'h0 && d == (e | MCAST_BIT));
    endfunction : da_byte_ok

    // ---------------------------------------------------------------
    // frame walk
    // ---------------------------------------------------------------
    always_comb begin
        nxt_st  = st_ff;
        nxt_idx = idx_ff;
        nxt_hit = hit_ff;
        nxt_phy = phy_ff;
        nxt_reg = reg_ff;
        nxt_dhi = dhi_ff;
        nxt_sq  = sq_ff;
        nxt_ok  = 1'b0;
        nxt_err = 1'b0;
        nxt_wr  = 1'b0;
        phy_ok  = (phy_ff == own_phy) || (!broadcast_disable && phy_ff == BCAST_PHY);
        unique case (st_ff)
            ST_IDLE: begin
                if (tx_valid) begin
                    nxt_hit = da_byte_ok(4'h0, tx_data, dest_addr_select);
                    nxt_idx = 4'h1;
                    nxt_st  = ST_DA;
                end
            end
            ST_DA: begin
                if (!tx_valid) begin
                    nxt_st = ST_IDLE;
                end else begin
                    nxt_hit = hit_ff && da_byte_ok(idx_ff, tx_data, dest_addr_select);
                    nxt_idx = idx_ff + 4'h1;
                    if (idx_ff == IDX_DA_LAST) begin
                        nxt_sq  = nxt_hit && buf_zero;
                        nxt_err = nxt_hit && buf_zero;
                        nxt_st  = (nxt_hit && !buf_zero) ? ST_HDR : ST_SKIP;
                    end
                end
            end
            ST_HDR: begin
                if (!tx_valid) begin
                    nxt_err = 1'b1;
                    nxt_st  = ST_IDLE;
                end else begin
                    nxt_idx = idx_ff + 4'h1;
                    if (idx_ff == IDX_PHY) nxt_phy = tx_data[4:0];
                    if (idx_ff == IDX_REG) nxt_reg = tx_data[4:0];
                    if (idx_ff == IDX_DHI) nxt_dhi = tx_data;
                    if (idx_ff == IDX_DLO) begin
                        nxt_st = ST_SKIP;
                        if (phy_ok) begin
                            nxt_ok = 1'b1;
                            nxt_wr = frame_write_enable;
                        end
                    end
                end
            end
            ST_SKIP: begin
                if (!tx_valid) begin
                    nxt_st = ST_IDLE;
                    nxt_sq = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_ff  <= ST_IDLE;
            idx_ff <= 4'h0;
            hit_ff <= 1'b0;
            phy_ff <= 5'h00;
            reg_ff <= 5'h00;
            dhi_ff <= 8'h00;
            sq_ff  <= 1'b0;
            ok_ff  <= 1'b0;
            err_ff <= 1'b0;
            wr_ff  <= 1'b0;
            dlo_ff <= 8'h00;
        end else begin
            st_ff  <= nxt_st;
            idx_ff <= nxt_idx;
            hit_ff <= nxt_hit;
            phy_ff <= nxt_phy;
            reg_ff <= nxt_reg;
            dhi_ff <= nxt_dhi;
            sq_ff  <= nxt_sq;
            ok_ff  <= nxt_ok;
            err_ff <= nxt_err;
            wr_ff  <= nxt_wr;
            dlo_ff <= tx_data;
        end
    end

    assign ev.ok      = ok_ff;
    assign ev.err     = err_ff;
    assign ev.wr      = wr_ff;
    assign ev.wr_reg  = reg_ff;
    assign ev.wr_data = {dhi_ff, dlo_ff};
    assign ev.squash  = sq_ff;
endmodule : pcf_parse

// ### testbench/pcf_mon_monitor.sv
// assertion checker for the control frame block
`timescale 1ns/10ps
module pcf_mon
    import pcf_pkg::*;
#(parameter int ADDR_W = 8) (
    input wire logic clk, reset, s_axi_awvalid, s_axi_awready,
    input wire logic s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready,
    input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid,
    input wire logic [1:0] s_axi_rresp,
    input wire logic [31:0] s_axi_rdata,
    input wire logic tx_valid, tx_out_valid, frame_wr_pulse, irq
);
    logic [4:0] gap_ff;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    always_ff @(posedge clk) gap_ff <= (reset | tx_valid) ? 5'h00 : gap_ff + {4'h0, ~&gap_ff};
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("address taken during answer");
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
    b_single_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
    rsv_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000
        && s_axi_rdata[13:9] == 5'h00) else $error("reserved bits nonzero");
    wr_cause_a: assert property (frame_wr_pulse |-> $past(tx_valid, 2))
        else $error("frame write without byte");
    wr_pulse_a: assert property (frame_wr_pulse |=> !frame_wr_pulse)
        else $error("frame write pulse too long");
    dly_bound_a: assert property (tx_out_valid |-> gap_ff <= 5'h11)
        else $error("delayed byte too late");
    rst_quiet_a: assert property ($fell(reset) |-> !irq && !s_axi_bvalid && !tx_out_valid)
        else $error("outputs busy after reset");
    cover property (frame_wr_pulse);
    cover property ($rose(irq));
    cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule : pcf_mon

// ### testbench/pcf_mac.sv
// frame source standing in for the mac
`timescale 1ns/10ps
module pcf_mac (
    input  wire logic        clk,
    input  wire logic        go,
    input  wire logic [3:0]  len,
    input  wire logic [79:0] frame,
    output logic             tx_valid,
    output logic [7:0]       tx_data
);
    logic [79:0] sh_ff;
    logic [3:0]  n_ff = 4'h0;
    logic [7:0]  last_ff = 8'h00;
    // one byte per clock, first octet first
    always @(posedge clk) begin
        if (tx_valid) last_ff <= tx_data;
        if (go && n_ff == 4'h0) begin
            sh_ff <= frame;
            n_ff <= len;
        end else if (n_ff != 4'h0) begin
            sh_ff <= sh_ff << 8;
            n_ff <= n_ff - 4'h1;
        end
    end
    // idle line shows inverse of last byte
    assign tx_valid = n_ff != 4'h0;
    assign tx_data = tx_valid ? sh_ff[79:72] : ~last_ff;
endmodule : pcf_mac

// ### testbench/phy_control_frame_config_bench.sv
// self-checking bench for the control frame block
`timescale 1ns/10ps
module phy_control_frame_config_bench;
    import pcf_pkg::*;
    localparam logic [7:0] CF = {CFG_IDX, 2'h0};
    localparam logic [7:0] ST = {STS_IDX, 2'h0};
    localparam logic [7:0] MK = {MSK_IDX, 2'h0};
    localparam logic [47:0] DA_M = {DEST_ADDR_B[47:40] | MCAST_BIT, DEST_ADDR_B[39:0]};
    logic clk = 0, reset = 1, go = 0, rx_half_full_event = 0, strap_write_enable = 1;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0, s_axi_bready = 1;
    logic s_axi_rready = 1, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, tx_valid, tx_out_valid, frame_wr_pulse, irq;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, tx_data, tx_out_data;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF, len = 0;
    logic [4:0] phy_addr = 5'h05, frame_wr_reg;
    logic [15:0] frame_wr_data;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [79:0] frame = 0;
    logic [20:0] wv = 0;
    int fails = 0, n_tests = 0, cyc = 0, nout = 0;
    pcf_top u_pcf_top (.*);
    pcf_mac u_pcf_mac (.*);
    always #2 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        nout <= go ? 0 : nout + tx_out_valid;
        if (frame_wr_pulse) wv <= {frame_wr_reg, frame_wr_data};
        if (cyc == 5000) begin
            fails = fails + 1;
            summarize();
        end
    end
    task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
        @(negedge clk);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
        @(posedge clk);
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        do begin
            @(negedge clk);
            ta = s_axi_awready;
            tw = s_axi_wready;
            tb = s_axi_bvalid;
            @(posedge clk);
            if (ta) s_axi_awvalid <= 0;
            if (tw) s_axi_wvalid <= 0;
        end while (!tb);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        logic ta, tr;
        logic [33:0] d;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        do begin
            @(negedge clk);
            ta = s_axi_arready;
            tr = s_axi_rvalid;
            d = {s_axi_rresp, s_axi_rdata};
            @(posedge clk);
            if (ta) s_axi_arvalid <= 0;
        end while (!tr);
        chk("read", d, e);
    endtask : rd
    task automatic send(input logic [79:0] f, input logic [3:0] l);
        frame <= f;
        len <= l;
        go <= 1;
        @(posedge clk);
        go <= 0;
        repeat (40) @(posedge clk);
    endtask : send
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize
    initial begin
        repeat (20) @(posedge clk);
        reset <= 0;
        repeat (6) @(posedge clk);
        rd(CF, 34'h1);
        wr(CF, 32'hFFFF_FFFF);
        rd(CF, 34'h1FF);
        rd(8'h40, {RESP_SLVERR, 32'h0});
        wr(CF, 32'h0);
        wr(MK, 32'h7);
        rx_half_full_event <= 1;
        @(posedge clk);
        rx_half_full_event <= 0;
        repeat (2) @(posedge clk);
        chk("irq", irq, 34'h1);
        rd(ST, 34'h4);
        wr(ST, 32'h4);
        rd(ST, 34'h0);
        $display("registers done");
        wr(CF, 32'hC5);
        send({DEST_ADDR_A, 3'h0, BCAST_PHY, 8'h03, 16'hABCD}, 4'hA);
        chk("irq", irq, 34'h1);
        chk("write", wv, {5'h03, 16'hABCD});
        chk("bytes", nout, 34'hA);
        rd(CF, 34'h40C5);
        rd(CF, 34'hC5);
        chk("irq", irq, 34'h0);
        $display("frame ok done");
        wr(CF, 32'h1E5);
        send({DEST_ADDR_A, 3'h0, 5'h05, 8'h04, 16'h1234}, 4'hA);
        send({DEST_ADDR_B, 3'h0, BCAST_PHY, 8'h04, 16'h1234}, 4'hA);
        rd(CF, 34'h1E5);
        send({DA_M, 3'h0, 5'h05, 8'h04, 16'h1234}, 4'hA);
        rd(CF, 34'h41E5);
        chk("write", wv, {5'h04, 16'h1234});
        $display("address match done");
        wr(CF, 32'hC5);
        send({DEST_ADDR_A, 3'h0, BCAST_PHY, 8'h03, 16'h0}, 4'h8);
        chk("irq", irq, 34'h1);
        rd(CF, 34'h80C5);
        wr(CF, 32'hC1);
        send({DEST_ADDR_A, 3'h0, BCAST_PHY, 8'h03, 16'hABCD}, 4'hA);
        chk("bytes", nout, 34'h6);
        rd(CF, 34'h80C1);
        $display("errors done");
        summarize();
    end
endmodule : phy_control_frame_config_bench
bind pcf_top pcf_mon #(.ADDR_W(ADDR_W)) u_pcf_mon (.*);
